// ===== logic/clp_defines.svh
// Constants for the core low-power signalling block: register offsets, field positions, reset values.
// Assumes a single AHB-Lite slave with 32-bit data, one word per register.
//
// Behaviour
// RQ1 - Low power request output always equals status bit 27.
// RQ2 - Exception level output always equals status bit 1.
// RQ3 - Error level output always equals status bit 2.
// RQ4 - A taken interrupt, even while powered down, sets the exception level bit.
// RQ5 - Debug mode output is high while in debug mode, entered by a debug exception.
// RQ6 - External agent may slow clocks and power down on low power request.
// RQ7 - External agent may speed clocks on exception, error or debug indication.
// RQ8 - Halt instruction in memory stage with idle bus stops clocks, freezes pipeline.
// RQ9 - Halt with busy bus stalls pipeline until idle, then stops clocks.
// RQ10 - While halted, timer runs and interrupt, NMI, reset, debug inputs stay monitored.
// RQ11 - Enabled interrupt, NMI, debug interrupt or reset wakes the halted core.
// RQ12 - Sleep indicator stays high for the whole instruction-initiated low-power state.
// RQ13 - On wake, drop sleep and enable clocks before the pipeline advances.
`ifndef CLP_DEFINES_SVH
`define CLP_DEFINES_SVH

`define CLP_OFF_STATUS 12'h000
`define CLP_OFF_CTRL 12'h004
`define CLP_OFF_STATE 12'h008
`define CLP_OFF_TIMER 12'h00c

`define CLP_BIT_LOW_POWER 27
`define CLP_BIT_ERR_LVL 2
`define CLP_BIT_EXC_LVL 1
`define CLP_BIT_DBG 0
`define CLP_BIT_HALT 1

`define CLP_STATUS_RST 32'h0000_0004
`define CLP_STATUS_WMASK 32'h0800_ff06
`define CLP_IM_LSB 10

`endif

// ===== logic/clp_pkg.sv
// Types for the core low-power signalling block.
// Assumes the defines header is included by users that need offsets.
package clp_pkg;
  typedef enum logic [1:0] {
    CLP_RUN = 2'b00,
    CLP_STALL = 2'b01,
    CLP_SLEEP = 2'b10
  } clp_state_t;

  typedef struct packed {
    logic [5:0] irq;
    logic nmi;
    logic soft_reset;
    logic cold_reset;
    logic dint;
  } clp_wake_t;

  typedef struct packed {
    logic low_power_request;
    logic exception_level;
    logic error_level;
    logic debug_mode;
    logic sleep;
  } clp_power_t;
endpackage : clp_pkg

// ===== logic/clp_halt_fsm.sv
// Halt-until-event sequencer: waits for an idle bus, gates clocks, wakes on events.
// Assumes wake inputs are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module clp_halt_fsm
  import clp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic halt_in_mem,
  input wire logic bus_busy,
  input wire logic wake,
  output clp_state_t state,
  output logic pipe_stall,
  output logic clock_enable,
  output logic sleep_out
);
  clp_state_t state_r;
  clp_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CLP_RUN: begin
        if (halt_in_mem && !wake) begin
          state_nxt = bus_busy ? CLP_STALL : CLP_SLEEP; // see RQ8 see RQ9
        end
      end
      CLP_STALL: begin
        if (wake) begin
          state_nxt = CLP_RUN;
        end else if (!bus_busy) begin
          state_nxt = CLP_SLEEP; // see RQ9
        end
      end
      CLP_SLEEP: begin
        if (wake) begin
          state_nxt = CLP_RUN; // see RQ11
        end
      end
      default: state_nxt = CLP_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= CLP_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state = state_r;
  assign pipe_stall = (state_r != CLP_RUN); // see RQ8 see RQ9
  // Clocks come back in the same cycle as the sleep flag drops.
  assign clock_enable = (state_r != CLP_SLEEP); // see RQ13
  assign sleep_out = (state_r == CLP_SLEEP); // see RQ12

  chk_sleep_wake_exit: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ11
    (state_r == CLP_SLEEP && wake) |=> !sleep_out)
    else $error("sleep not left on wake");
  chk_stall_idle_sleep: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ9
    (state_r == CLP_STALL && !bus_busy && !wake) |=> sleep_out)
    else $error("stall did not enter sleep on idle bus");
  chk_sleep_hold: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ12
    (sleep_out && !wake) |=> sleep_out && !clock_enable)
    else $error("sleep dropped without wake");
  chk_busy_no_sleep: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ9
    (state_r == CLP_RUN && halt_in_mem && bus_busy && !wake) |=> !sleep_out && pipe_stall)
    else $error("slept with busy bus");
endmodule : clp_halt_fsm
`default_nettype wire

// ===== logic/clp_timer.sv
// Free-running timer that keeps counting while the core clocks are gated.
// Assumes it sits on the ungated clock.
`timescale 1ns/1ps
`default_nettype none
module clp_timer (
  input wire logic hclk,
  input wire logic hresetn,
  output logic [31:0] count
);
  logic [31:0] count_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= 32'h0000_0000;
    end else begin
      count_r <= count_r + 32'h0000_0001; // see RQ10
    end
  end

  assign count = count_r;

  chk_timer_runs: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ10
    $past(hresetn) |-> count_r == $past(count_r) + 32'h0000_0001)
    else $error("timer stopped");
endmodule : clp_timer
`default_nettype wire

// ===== logic/clp_core_power.sv
// Low-power signalling top: status bits, pin mirrors, debug mode and halt sleep, AHB-Lite slave.
// Assumes one AHB-Lite master, single word transfers, inputs synchronous to hclk.
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "clp_defines.svh"
module clp_core_power
  import clp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic halt_in_mem,
  input wire logic bus_busy,
  input wire logic [5:0] interrupt_inputs,
  input wire logic nmi_in,
  input wire logic soft_reset_in,
  input wire logic cold_reset_in,
  input wire logic debug_interrupt_in,
  input wire logic error_event,
  input wire logic exception_return,
  input wire logic debug_return,
  output logic low_power_request_out,
  output logic exception_level_out,
  output logic error_level_out,
  output logic debug_mode_out,
  output logic sleep_indicator_out,
  output logic core_clock_enable,
  output logic pipeline_stall,
  output logic [31:0] timer_count
);
  logic [31:0] status_r;
  logic debug_r;
  logic wr_pend_r;
  logic [11:0] addr_r;
  logic [31:0] rdata_r;
  logic irq_take;
  logic dbg_take;
  logic wake;
  logic sw_wr;
  clp_wake_t wake_in;
  clp_state_t state;

  ////////////////////////////////////////////////////////////////////////////////
  // Event detection.

  assign wake_in = '{irq: interrupt_inputs, nmi: nmi_in, soft_reset: soft_reset_in,
                     cold_reset: cold_reset_in, dint: debug_interrupt_in};

  // An interrupt is taken when an unmasked line is high and no exception level, error level or debug mode is active.
  assign irq_take = (|(wake_in.irq & status_r[`CLP_IM_LSB +: 6])) && !status_r[`CLP_BIT_EXC_LVL] &&
                    !status_r[`CLP_BIT_ERR_LVL] && !debug_r; // see RQ4
  assign dbg_take = wake_in.dint && !debug_r; // see RQ5
  assign wake = irq_take || wake_in.nmi || wake_in.soft_reset || wake_in.cold_reset ||
                dbg_take; // see RQ10 see RQ11

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer and timer.

  clp_halt_fsm u_fsm (
    .hclk(hclk),
    .hresetn(hresetn),
    .halt_in_mem(halt_in_mem),
    .bus_busy(bus_busy),
    .wake(wake),
    .state(state),
    .pipe_stall(pipeline_stall),
    .clock_enable(core_clock_enable),
    .sleep_out(sleep_indicator_out)
  );

  clp_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .count(timer_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY.

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      addr_r <= haddr;
    end
  end

  assign sw_wr = wr_pend_r && (addr_r == `CLP_OFF_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr)
        `CLP_OFF_STATUS: rdata_r <= status_r;
        `CLP_OFF_CTRL: rdata_r <= {31'h0000_0000, debug_r};
        `CLP_OFF_STATE: rdata_r <= {30'h0000_0000, state};
        `CLP_OFF_TIMER: rdata_r <= timer_count;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign hrdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Status register; hardware set wins over a software write.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= `CLP_STATUS_RST;
    end else begin
      if (sw_wr) begin
        status_r <= (status_r & ~`CLP_STATUS_WMASK) | (hwdata & `CLP_STATUS_WMASK);
      end else if (exception_return) begin
        status_r[`CLP_BIT_EXC_LVL] <= 1'b0;
        status_r[`CLP_BIT_ERR_LVL] <= 1'b0;
      end
      if (irq_take) begin
        status_r[`CLP_BIT_EXC_LVL] <= 1'b1; // see RQ4
      end
      if (error_event || wake_in.nmi || wake_in.soft_reset || wake_in.cold_reset) begin
        status_r[`CLP_BIT_ERR_LVL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_r <= 1'b0;
    end else if (dbg_take) begin
      debug_r <= 1'b1; // see RQ5
    end else if (debug_return) begin
      debug_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power signalling pins.

  assign low_power_request_out = status_r[`CLP_BIT_LOW_POWER]; // see RQ1
  assign exception_level_out = status_r[`CLP_BIT_EXC_LVL]; // see RQ2
  assign error_level_out = status_r[`CLP_BIT_ERR_LVL]; // see RQ3
  assign debug_mode_out = debug_r; // see RQ5

  chk_rp_mirror: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ1
    (sw_wr && !error_event) |=> low_power_request_out == $past(hwdata[`CLP_BIT_LOW_POWER]))
    else $error("low power request does not follow bit 27");
  chk_irq_sets_exl: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ4
    irq_take |=> exception_level_out)
    else $error("interrupt did not raise exception level");
  chk_exl_follows: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ2
    (exception_return && !sw_wr && !irq_take) |=> !exception_level_out)
    else $error("exception level output did not clear");
  chk_erl_sets: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ3
    error_event |=> error_level_out)
    else $error("error level output not raised");
  chk_debug_entry: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ5
    dbg_take |=> $rose(debug_mode_out))
    else $error("debug mode not entered");
  chk_wake_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // see RQ13
    (sleep_indicator_out && wake) |=> core_clock_enable && !sleep_indicator_out)
    else $error("clocks not restored on wake");
endmodule : clp_core_power
`default_nettype wire

// ===== bench/clp_power_agent.sv
// Model of the external clock and power agent that watches the power pins.
// Assumes the pins are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module clp_power_agent (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic low_power_request_out,
  input wire logic exception_level_out,
  input wire logic error_level_out,
  input wire logic debug_mode_out,
  input wire logic fast_on_event,
  output logic slow_clock
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_clock <= 1'b0;
    end else if (!low_power_request_out) begin
      slow_clock <= 1'b0;
    end else if (fast_on_event && (exception_level_out || error_level_out || debug_mode_out)) begin
      slow_clock <= 1'b0;
    end else begin
      slow_clock <= 1'b1;
    end
  end
endmodule : clp_power_agent
`default_nettype wire

// ===== bench/clp_core_power_tb_top.sv
// Testbench for the low-power signalling block: bus tasks, pin and sleep checks.
// Assumes a zero-wait slave and the power agent model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "clp_defines.svh"
module clp_core_power_tb_top;
  import clp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, halt_in_mem, bus_busy, nmi_in, soft_reset_in, cold_reset_in;
  logic debug_interrupt_in, error_event, exception_return, debug_return, fast_on_event;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, timer_count, t0;
  logic [5:0] interrupt_inputs;
  logic hreadyout, hresp, low_power_request_out, exception_level_out, error_level_out;
  logic debug_mode_out, sleep_indicator_out, core_clock_enable, pipeline_stall, slow_clock;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  clp_core_power u_clp_core_power (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .halt_in_mem, .bus_busy,
    .interrupt_inputs, .nmi_in, .soft_reset_in, .cold_reset_in, .debug_interrupt_in, .error_event,
    .exception_return, .debug_return, .low_power_request_out, .exception_level_out,
    .error_level_out, .debug_mode_out, .sleep_indicator_out, .core_clock_enable, .pipeline_stall,
    .timer_count);
  clp_power_agent u_clp_power_agent (.hclk, .hresetn, .low_power_request_out,
    .exception_level_out, .error_level_out, .debug_mode_out, .fast_on_event, .slow_clock);
  always #10 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_pin(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_pin
  task automatic bus_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus_xfer
  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    bus_xfer(1'b1, addr, wd, rd);
  endtask : wr
  task automatic rd_check(input string what, input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    bus_xfer(1'b0, addr, 32'h0000_0000, rd);
    check_word(what, exp, rd);
    check_pin("hresp", 1'b0, hresp);
  endtask : rd_check
  task automatic pins(input logic lp, input logic exception_level_bit, input logic error_level_bit);
    @(negedge hclk);
    check_pin("low_power_request_out", lp, low_power_request_out);
    check_pin("exception_level_out", exception_level_bit, exception_level_out);
    check_pin("error_level_out", error_level_bit, error_level_out);
  endtask : pins
  task automatic halt_st(input logic slp, input logic cken, input logic stall);
    @(negedge hclk);
    check_pin("sleep_indicator_out", slp, sleep_indicator_out);
    check_pin("core_clock_enable", cken, core_clock_enable);
    check_pin("pipeline_stall", stall, pipeline_stall);
  endtask : halt_st
  task automatic exc_return;
    @(posedge hclk);
    exception_return <= 1'b1;
    @(posedge hclk);
    exception_return <= 1'b0;
  endtask : exc_return
  // Sleeps with every interrupt line high but masked, then wakes on one of cold reset, soft reset, debug.
  task automatic sleep_wake(input logic [2:0] src);
    @(posedge hclk);
    halt_in_mem <= 1'b1;
    interrupt_inputs <= 6'h3f;
    repeat (3) @(posedge hclk);
    halt_st(1'b1, 1'b0, 1'b1);
    rd_check("state", `CLP_OFF_STATE, {30'h0000_0000, CLP_SLEEP});
    @(posedge hclk);
    interrupt_inputs <= 6'h00;
    halt_in_mem <= 1'b0;
    {cold_reset_in, soft_reset_in, debug_interrupt_in} <= src;
    @(posedge hclk);
    {cold_reset_in, soft_reset_in, debug_interrupt_in} <= 3'b000;
    halt_st(1'b0, 1'b1, 1'b0);
  endtask : sleep_wake
  ////////////////////////////////////////////////////////////////////////////
  // The timeout stops a hung handshake or sequence and counts it as a mismatch.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, halt_in_mem, bus_busy, nmi_in, soft_reset_in, cold_reset_in} = '0;
    {debug_interrupt_in, error_event, exception_return, debug_return} = '0;
    fast_on_event = 1'b1;
    haddr = 12'h000;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    interrupt_inputs = 6'h00;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    pins(1'b0, 1'b0, 1'b1);
    rd_check("status", `CLP_OFF_STATUS, `CLP_STATUS_RST);
    wr(`CLP_OFF_STATUS, 32'h0800_0002);
    pins(1'b1, 1'b1, 1'b0);
    @(posedge hclk);
    fast_on_event <= 1'b0;
    repeat (2) @(posedge hclk);
    fast_on_event <= 1'b1;
    @(negedge hclk);
    check_pin("slow_clock", 1'b1, slow_clock);
    @(negedge hclk);
    check_pin("slow_clock", 1'b0, slow_clock);
    rd_check("status", `CLP_OFF_STATUS, 32'h0800_0002);
    wr(`CLP_OFF_STATUS, 32'h0000_fc04);
    pins(1'b0, 1'b0, 1'b1);
    @(posedge hclk);
    exception_return <= 1'b1;
    @(posedge hclk);
    exception_return <= 1'b0;
    pins(1'b0, 1'b0, 1'b0);
    @(posedge hclk);
    halt_in_mem <= 1'b1;
    bus_busy <= 1'b1;
    repeat (3) @(posedge hclk);
    halt_st(1'b0, 1'b1, 1'b1);
    @(posedge hclk);
    bus_busy <= 1'b0;
    repeat (2) @(posedge hclk);
    halt_st(1'b1, 1'b0, 1'b1);
    t0 = timer_count;
    repeat (4) @(negedge hclk);
    check_word("timer_count", t0 + 32'd4, timer_count);
    halt_st(1'b1, 1'b0, 1'b1);
    @(posedge hclk);
    interrupt_inputs <= 6'h01;
    halt_in_mem <= 1'b0;
    @(posedge hclk);
    interrupt_inputs <= 6'h00;
    halt_st(1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b1, 1'b0);
    @(posedge hclk);
    halt_in_mem <= 1'b1;
    repeat (2) @(posedge hclk);
    halt_st(1'b1, 1'b0, 1'b1);
    @(posedge hclk);
    nmi_in <= 1'b1;
    halt_in_mem <= 1'b0;
    @(posedge hclk);
    nmi_in <= 1'b0;
    halt_st(1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b1, 1'b1);
    @(posedge hclk);
    debug_interrupt_in <= 1'b1;
    @(posedge hclk);
    debug_interrupt_in <= 1'b0;
    @(negedge hclk);
    check_pin("debug_mode_out", 1'b1, debug_mode_out);
    rd_check("debug", `CLP_OFF_CTRL, 32'h0000_0001);
    @(posedge hclk);
    debug_return <= 1'b1;
    @(posedge hclk);
    debug_return <= 1'b0;
    @(negedge hclk);
    check_pin("debug_mode_out", 1'b0, debug_mode_out);
    rd_check("unmapped", 12'h010, 32'h0000_0000);
    wr(`CLP_OFF_STATUS, 32'h0000_0000);
    pins(1'b0, 1'b0, 1'b0);
    @(posedge hclk);
    error_event <= 1'b1;
    @(posedge hclk);
    error_event <= 1'b0;
    pins(1'b0, 1'b0, 1'b1);
    exc_return();
    pins(1'b0, 1'b0, 1'b0);
    sleep_wake(3'b100);
    pins(1'b0, 1'b0, 1'b1);
    exc_return();
    sleep_wake(3'b010);
    pins(1'b0, 1'b0, 1'b1);
    sleep_wake(3'b001);
    check_pin("debug_mode_out", 1'b1, debug_mode_out);
    wrap_up();
  end
endmodule : clp_core_power_tb_top
`default_nettype wire
